// [logic/asfm_pkg.sv]
// Package with constants, encodings and carrier types of the ALU status and multiplier front block.
package asfm_pkg;

	localparam int FIX_W  = 32;
	localparam int REG_W  = 40;
	localparam int PROD_W = 80;
	localparam int LSB_PAD = 8;

	// Status word field positions.
	localparam int ST_ZERO_BIT  = 0;
	localparam int ST_OVF_BIT   = 1;
	localparam int ST_NEG_BIT   = 2;
	localparam int ST_CARRY_BIT = 3;
	localparam int ST_SIGN_BIT  = 4;
	localparam int ST_INV_BIT   = 5;
	localparam int ST_FLOAT_BIT = 10;
	localparam int ST_HIST_LSB  = 24;
	localparam int ST_HIST_MSB  = 31;

	// Sticky word field positions.
	localparam int SK_UNDER_BIT = 0;
	localparam int SK_FOVF_BIT  = 1;
	localparam int SK_XOVF_BIT  = 2;
	localparam int SK_INV_BIT   = 5;

	localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
	localparam logic [31:0] STICKY_RESET = 32'h0000_0000;
	localparam logic [31:0] FIX_MAX_POS  = 32'h7FFF_FFFF;
	localparam logic [31:0] FIX_MAX_NEG  = 32'h8000_0000;
	localparam logic signed [9:0] FP_EXP_MAX = 10'sd127;

	typedef enum logic [4:0] {
		ASFM_OP_ADD    = 5'b0_0000,
		ASFM_OP_SUB    = 5'b0_0001,
		ASFM_OP_ADDC   = 5'b0_0010,
		ASFM_OP_SUBB   = 5'b0_0011,
		ASFM_OP_AVG    = 5'b0_0100,
		ASFM_OP_COMP   = 5'b0_0101,
		ASFM_OP_INCC   = 5'b0_0110,
		ASFM_OP_DECC   = 5'b0_0111,
		ASFM_OP_INC    = 5'b0_1000,
		ASFM_OP_DEC    = 5'b0_1001,
		ASFM_OP_NEG    = 5'b0_1010,
		ASFM_OP_MAG    = 5'b0_1011,
		ASFM_OP_PASS   = 5'b0_1100,
		ASFM_OP_AND    = 5'b0_1101,
		ASFM_OP_OR     = 5'b0_1110,
		ASFM_OP_XOR    = 5'b0_1111,
		ASFM_OP_NOT    = 5'b1_0000,
		ASFM_OP_MIN    = 5'b1_0001,
		ASFM_OP_MAX    = 5'b1_0010,
		ASFM_OP_LIMIT  = 5'b1_0011,
		ASFM_OP_FLOAT  = 5'b1_0100,
		ASFM_OP_FCOMP  = 5'b1_0101,
		ASFM_OP_FMAG   = 5'b1_0110,
		ASFM_OP_FSIGX  = 5'b1_0111,
		ASFM_OP_FTOFIX = 5'b1_1000
	} asfm_alu_op_t;

	typedef enum logic [2:0] {
		ASFM_MD_NONE   = 3'b000,
		ASFM_MD_TO_RF  = 3'b001,
		ASFM_MD_LOAD   = 3'b010,
		ASFM_MD_ACCADD = 3'b011,
		ASFM_MD_ACCSUB = 3'b100,
		ASFM_MD_FLOAT  = 3'b101
	} asfm_mult_dest_t;

	typedef struct packed {
		logic               valid;
		asfm_alu_op_t       op;
		logic [REG_W-1:0]   x;
		logic [REG_W-1:0]   y;
	} asfm_alu_req_t;

	// Outcome of the floating-point datapath, already rounded, for the current ALU operation.
	typedef struct packed {
		logic [REG_W-1:0]   result;
		logic               zero;
		logic               negative;
		logic               underflow;
		logic signed [9:0]  exponent;
		logic               in_nan;
		logic               inf_add_opposite;
		logic               inf_sub_like;
		logic               conv_overflow;
		logic               conv_infinity;
		logic               x_negative;
		logic               x_greater;
	} asfm_fp_stat_t;

	typedef struct packed {
		logic               valid;
		asfm_mult_dest_t    dest;
		logic               acc_sel;
		logic               fractional;
		logic               x_signed;
		logic               y_signed;
		logic [REG_W-1:0]   x;
		logic [REG_W-1:0]   y;
		logic [REG_W-1:0]   fp_product;
	} asfm_mult_req_t;

	typedef struct packed {
		logic               we;
		logic [REG_W-1:0]   data;
	} asfm_rf_wr_t;

endpackage

// [logic/asfm_core.sv]
// ALU status-flag generation with compare history, and the fixed-point multiplier front end with two accumulators.
`timescale 1ns/100ps

// Behaviour
// - Each ALU flag is registered at the cycle end and visible next cycle.
// - A software write of either status word beats the same-cycle ALU flag update.
// - Zero flag set on zero result or float underflow, else cleared.
// - Underflow sticky set for float results and float-to-fixed when below smallest value.
// - Negative flag follows the result sign for every ALU operation.
// - Fixed overflow: top two result bits differ sets overflow flag and fixed sticky.
// - Float overflow: unbiased exponent above 127 sets overflow flag and float sticky.
// - Carry is the carry out for arithmetic; zero for logic, pass, min, max, compare, magnitude, limit.
// - Add-with-carry and subtract-with-borrow use the current carry flag as carry in.
// - Input sign flag set only for magnitude and significand extract on negative input.
// - Invalid flag and sticky on NaN, bad infinity sums, unclamped conversion overflow or infinity.
// - Float operation flag set for float operations, cleared for fixed ones.
// - Compare shifts history toward bit 24, bit 31 gets X greater than Y.
// - Invalid sticky sits at bit 5 of the sticky word.
// - Operations only set sticky flags; unaffected flags keep their value.
// - Fixed multiply takes 32-bit operands giving 80 bits; float takes 32 or 40 bits.
// - Multiplier reads operands early and writes late, so source may equal destination.
// - Fixed multiplier operands are the upper 32 bits of 40-bit sources.
// - Signed fractional times signed fractional product is shifted left one bit.
// - Fixed products go to register file or an accumulator; float products to register file.
// - Both operands share integer or fractional format; each has its own signedness.
// - Multiply-accumulate may add to or subtract from the accumulator.
// - A sticky flag stays high until software clears it.
// - Status bits: 0 zero, 1 overflow, 2 negative, 3 carry, 4 sign, 5 invalid, 10 float.
// - Clamp enable saturates fixed overflows and gates the conversion invalid condition.
module asfm_core #(
	parameter int ACC_COUNT = 2
) (
	input  wire logic                          core_clk_in,
	input  wire logic                          rstn_in,
	input  wire logic                          overflow_clamp_enable_in,
	input  wire asfm_pkg::asfm_alu_req_t       alu_req_in,
	input  wire asfm_pkg::asfm_fp_stat_t       fp_stat_in,
	input  wire logic                          status_we_in,
	input  wire logic [31:0]                   status_wdata_in,
	input  wire logic                          sticky_we_in,
	input  wire logic [31:0]                   sticky_wdata_in,
	input  wire asfm_pkg::asfm_mult_req_t      mult_req_in,
	output logic [31:0]                        arith_status_word_out,
	output logic [31:0]                        sticky_status_word_out,
	output asfm_pkg::asfm_rf_wr_t              alu_wr_out,
	output asfm_pkg::asfm_rf_wr_t              mult_wr_out,
	output logic [ACC_COUNT*asfm_pkg::PROD_W-1:0] mult_result_accumulator_out
);

	localparam int W = asfm_pkg::FIX_W;
	localparam int P = asfm_pkg::PROD_W;

	logic [31:0]           arith_status_word;
	logic [31:0]           sticky_status_word;
	logic [31:0]           next_arith_status_word;
	logic [31:0]           next_sticky_status_word;
	asfm_pkg::asfm_rf_wr_t alu_wr;
	asfm_pkg::asfm_rf_wr_t next_alu_wr;

	logic [W-1:0]  opx;
	logic [W-1:0]  opy;
	logic [W-1:0]  add_a;
	logic [W-1:0]  add_b;
	logic          add_cin;
	logic [W:0]    sum_u;
	logic [W:0]    sum_s;
	logic          carry_in_flag;

	// Fixed operands are the upper word of the 40-bit register, low byte ignored.
	assign opx           = alu_req_in.x[asfm_pkg::REG_W-1 -: W];
	assign opy           = alu_req_in.y[asfm_pkg::REG_W-1 -: W];
	assign carry_in_flag = arith_status_word[asfm_pkg::ST_CARRY_BIT];

	// One shared adder serves every fixed arithmetic operation; subtraction adds the inverted operand.
	always_comb begin
		add_a   = opx;
		add_b   = opy;
		add_cin = 1'b0;
		case (alu_req_in.op)
			asfm_pkg::ASFM_OP_SUB,
			asfm_pkg::ASFM_OP_COMP: begin
				add_b   = ~opy;
				add_cin = 1'b1;
			end
			asfm_pkg::ASFM_OP_ADDC: begin
				add_cin = carry_in_flag;
			end
			asfm_pkg::ASFM_OP_SUBB: begin
				add_b   = ~opy;
				add_cin = carry_in_flag;
			end
			asfm_pkg::ASFM_OP_INCC: begin
				add_b   = '0;
				add_cin = carry_in_flag;
			end
			asfm_pkg::ASFM_OP_DECC: begin
				add_b   = '1;
				add_cin = carry_in_flag;
			end
			asfm_pkg::ASFM_OP_INC: begin
				add_b   = '0;
				add_cin = 1'b1;
			end
			asfm_pkg::ASFM_OP_DEC: begin
				add_b = '1;
			end
			asfm_pkg::ASFM_OP_NEG,
			asfm_pkg::ASFM_OP_MAG: begin
				add_a   = '0;
				add_b   = ~opx;
				add_cin = 1'b1;
			end
			default: begin
				add_a   = opx;
				add_b   = opy;
				add_cin = 1'b0;
			end
		endcase
	end

	assign sum_u = {1'b0, add_a} + {1'b0, add_b} + {{W{1'b0}}, add_cin};
	assign sum_s = {add_a[W-1], add_a} + {add_b[W-1], add_b} + {{W{1'b0}}, add_cin};

	logic [W-1:0]  fx_res;
	logic          fx_ovf;
	logic          fx_carry;
	logic          x_gt_y;
	logic          is_float;
	logic          is_compare;

	assign x_gt_y     = $signed(opx) > $signed(opy);
	assign is_float   = alu_req_in.op inside {asfm_pkg::ASFM_OP_FLOAT, asfm_pkg::ASFM_OP_FCOMP,
		asfm_pkg::ASFM_OP_FMAG, asfm_pkg::ASFM_OP_FSIGX, asfm_pkg::ASFM_OP_FTOFIX};
	assign is_compare = alu_req_in.op inside {asfm_pkg::ASFM_OP_COMP, asfm_pkg::ASFM_OP_FCOMP};

	// Fixed result, overflow and carry before clamping.
	always_comb begin
		fx_res   = sum_u[W-1:0];
		fx_ovf   = sum_s[W] ^ sum_s[W-1];
		fx_carry = sum_u[W];
		case (alu_req_in.op)
			asfm_pkg::ASFM_OP_AVG: begin
				fx_res = sum_s[W:1];
				fx_ovf = 1'b0;
			end
			asfm_pkg::ASFM_OP_MAG: begin
				fx_res   = opx[W-1] ? sum_u[W-1:0] : opx;
				fx_ovf   = opx[W-1] & (sum_s[W] ^ sum_s[W-1]);
				fx_carry = 1'b0;
			end
			asfm_pkg::ASFM_OP_COMP: begin
				fx_ovf   = 1'b0;
				fx_carry = 1'b0;
			end
			asfm_pkg::ASFM_OP_PASS,
			asfm_pkg::ASFM_OP_AND,
			asfm_pkg::ASFM_OP_OR,
			asfm_pkg::ASFM_OP_XOR,
			asfm_pkg::ASFM_OP_NOT,
			asfm_pkg::ASFM_OP_MIN,
			asfm_pkg::ASFM_OP_MAX,
			asfm_pkg::ASFM_OP_LIMIT: begin
				fx_ovf   = 1'b0;
				fx_carry = 1'b0;
				case (alu_req_in.op)
					asfm_pkg::ASFM_OP_PASS: fx_res = opx;
					asfm_pkg::ASFM_OP_AND: fx_res  = opx & opy;
					asfm_pkg::ASFM_OP_OR: fx_res   = opx | opy;
					asfm_pkg::ASFM_OP_XOR: fx_res  = opx ^ opy;
					asfm_pkg::ASFM_OP_NOT: fx_res  = ~opx;
					asfm_pkg::ASFM_OP_MIN: fx_res  = x_gt_y ? opy : opx;
					asfm_pkg::ASFM_OP_MAX: fx_res  = x_gt_y ? opx : opy;
					default: begin
						// Limit X to the band of plus and minus the magnitude of Y.
						if ($signed(opx) > $signed(opy[W-1] ? -opy : opy)) begin
							fx_res = opy[W-1] ? -opy : opy;
						end else if ($signed(opx) < $signed(opy[W-1] ? opy : -opy)) begin
							fx_res = opy[W-1] ? opy : -opy;
						end else begin
							fx_res = opx;
						end
					end
				endcase
			end
			default: begin
				fx_res   = sum_u[W-1:0];
				fx_ovf   = sum_s[W] ^ sum_s[W-1];
				fx_carry = sum_u[W];
			end
		endcase
	end

	// Clamping to full scale; overflow and carry describe the unclamped result, zero and negative the clamped one.
	logic [W-1:0] fx_out;
	assign fx_out = (overflow_clamp_enable_in && fx_ovf)
		? (sum_s[W] ? asfm_pkg::FIX_MAX_NEG : asfm_pkg::FIX_MAX_POS) : fx_res;

	// Flag and sticky update, then software writes on top.
	logic f_zero;
	logic f_ovf;
	logic f_neg;
	logic f_carry;
	logic f_sign;
	logic f_inv;
	logic f_under;
	logic f_fovf;
	logic f_gt;

	always_comb begin
		f_zero  = (fx_out == '0);
		f_ovf   = fx_ovf;
		f_neg   = fx_out[W-1];
		f_carry = fx_carry;
		f_sign  = (alu_req_in.op == asfm_pkg::ASFM_OP_MAG) && opx[W-1];
		f_inv   = 1'b0;
		f_under = 1'b0;
		f_fovf  = 1'b0;
		f_gt    = x_gt_y;
		if (is_float) begin
			f_under = fp_stat_in.underflow;
			f_zero  = fp_stat_in.zero || fp_stat_in.underflow;
			f_fovf  = fp_stat_in.exponent > asfm_pkg::FP_EXP_MAX;
			f_ovf   = f_fovf;
			f_neg   = fp_stat_in.negative;
			f_carry = 1'b0;
			f_sign  = (alu_req_in.op inside {asfm_pkg::ASFM_OP_FMAG, asfm_pkg::ASFM_OP_FSIGX})
				&& fp_stat_in.x_negative;
			f_inv   = fp_stat_in.in_nan || fp_stat_in.inf_add_opposite || fp_stat_in.inf_sub_like
				|| (!overflow_clamp_enable_in && (alu_req_in.op == asfm_pkg::ASFM_OP_FTOFIX)
				&& (fp_stat_in.conv_overflow || fp_stat_in.conv_infinity));
			f_gt    = fp_stat_in.x_greater;
		end
	end

	always_comb begin
		next_arith_status_word  = arith_status_word;
		next_sticky_status_word = sticky_status_word;
		if (alu_req_in.valid) begin
			next_arith_status_word[asfm_pkg::ST_ZERO_BIT]  = f_zero;
			next_arith_status_word[asfm_pkg::ST_OVF_BIT]   = f_ovf;
			next_arith_status_word[asfm_pkg::ST_NEG_BIT]   = f_neg;
			next_arith_status_word[asfm_pkg::ST_CARRY_BIT] = f_carry;
			next_arith_status_word[asfm_pkg::ST_SIGN_BIT]  = f_sign;
			next_arith_status_word[asfm_pkg::ST_INV_BIT]   = f_inv;
			next_arith_status_word[asfm_pkg::ST_FLOAT_BIT] = is_float;
			if (is_compare) begin
				next_arith_status_word[asfm_pkg::ST_HIST_MSB:asfm_pkg::ST_HIST_LSB] =
					{f_gt, arith_status_word[asfm_pkg::ST_HIST_MSB:asfm_pkg::ST_HIST_LSB+1]};
			end
			// Sticky bits are only ever OR-ed in here.
			next_sticky_status_word[asfm_pkg::SK_UNDER_BIT] = sticky_status_word[asfm_pkg::SK_UNDER_BIT]
				| f_under;
			next_sticky_status_word[asfm_pkg::SK_FOVF_BIT]  = sticky_status_word[asfm_pkg::SK_FOVF_BIT]
				| f_fovf;
			next_sticky_status_word[asfm_pkg::SK_XOVF_BIT]  = sticky_status_word[asfm_pkg::SK_XOVF_BIT]
				| (!is_float && fx_ovf);
			next_sticky_status_word[asfm_pkg::SK_INV_BIT]   = sticky_status_word[asfm_pkg::SK_INV_BIT]
				| f_inv;
		end
		if (status_we_in) begin
			next_arith_status_word = status_wdata_in;
		end
		if (sticky_we_in) begin
			next_sticky_status_word = sticky_wdata_in;
		end
	end

	always_comb begin
		next_alu_wr.we   = alu_req_in.valid && !is_compare;
		next_alu_wr.data = is_float && (alu_req_in.op != asfm_pkg::ASFM_OP_FTOFIX) ? fp_stat_in.result
			: {(is_float ? fp_stat_in.result[asfm_pkg::REG_W-1 -: W] : fx_out), {asfm_pkg::LSB_PAD{1'b0}}};
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			arith_status_word  <= asfm_pkg::STATUS_RESET;
			sticky_status_word <= asfm_pkg::STICKY_RESET;
			alu_wr             <= '0;
		end else begin
			arith_status_word  <= next_arith_status_word;
			sticky_status_word <= next_sticky_status_word;
			alu_wr             <= next_alu_wr;
		end
	end

	// Multiplier front end. Operands are sampled combinationally and the answer is registered, so the
	// register file may read a location and see it overwritten by the same instruction's result.
	logic [W-1:0] m_x;
	logic [W-1:0] m_y;
	logic [P-1:0] m_xe;
	logic [P-1:0] m_ye;
	logic [P-1:0] m_raw;
	logic [P-1:0] m_prod;

	assign m_x  = mult_req_in.x[asfm_pkg::REG_W-1 -: W];
	assign m_y  = mult_req_in.y[asfm_pkg::REG_W-1 -: W];
	assign m_xe = {{(P-W){mult_req_in.x_signed & m_x[W-1]}}, m_x};
	assign m_ye = {{(P-W){mult_req_in.y_signed & m_y[W-1]}}, m_y};
	assign m_raw = m_xe * m_ye;
	assign m_prod = (mult_req_in.fractional && mult_req_in.x_signed && mult_req_in.y_signed)
		? {m_raw[P-2:0], 1'b0} : m_raw;

	logic [P-1:0]          acc [ACC_COUNT];
	logic [P-1:0]          next_acc [ACC_COUNT];
	asfm_pkg::asfm_rf_wr_t mult_wr;
	asfm_pkg::asfm_rf_wr_t next_mult_wr;

	always_comb begin
		for (int i = 0; i < ACC_COUNT; i++) begin
			next_acc[i] = acc[i];
		end
		next_mult_wr.we   = 1'b0;
		next_mult_wr.data = mult_wr.data;
		if (mult_req_in.valid) begin
			case (mult_req_in.dest)
				asfm_pkg::ASFM_MD_TO_RF: begin
					// Fractional results come from the upper word, integer ones from the lower.
					next_mult_wr.we   = 1'b1;
					next_mult_wr.data = {(mult_req_in.fractional ? m_prod[2*W-1:W] : m_prod[W-1:0]),
						{asfm_pkg::LSB_PAD{1'b0}}};
				end
				asfm_pkg::ASFM_MD_LOAD: begin
					next_acc[mult_req_in.acc_sel] = m_prod;
				end
				asfm_pkg::ASFM_MD_ACCADD: begin
					next_acc[mult_req_in.acc_sel] = acc[mult_req_in.acc_sel] + m_prod;
				end
				asfm_pkg::ASFM_MD_ACCSUB: begin
					next_acc[mult_req_in.acc_sel] = acc[mult_req_in.acc_sel] - m_prod;
				end
				asfm_pkg::ASFM_MD_FLOAT: begin
					next_mult_wr.we   = 1'b1;
					next_mult_wr.data = mult_req_in.fp_product;
				end
				default: begin
					next_mult_wr.we = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			for (int i = 0; i < ACC_COUNT; i++) begin
				acc[i] <= '0;
			end
			mult_wr <= '0;
		end else begin
			for (int i = 0; i < ACC_COUNT; i++) begin
				acc[i] <= next_acc[i];
			end
			mult_wr <= next_mult_wr;
		end
	end

	always_comb begin
		for (int i = 0; i < ACC_COUNT; i++) begin
			mult_result_accumulator_out[i*P +: P] = acc[i];
		end
	end

	assign arith_status_word_out  = arith_status_word;
	assign sticky_status_word_out = sticky_status_word;
	assign alu_wr_out             = alu_wr;
	assign mult_wr_out            = mult_wr;

endmodule // asfm_core

// [verification/asfm_core_monitor.sv]
// Assertion checker that watches the ports of the ALU status and multiplier block.
`timescale 1ns/100ps
module asfm_core_monitor #(
	parameter int ACC_COUNT = 2
) (
	input wire logic                                  core_clk_in,
	input wire logic                                  rstn_in,
	input wire logic                                  overflow_clamp_enable_in,
	input wire asfm_pkg::asfm_alu_req_t               alu_req_in,
	input wire asfm_pkg::asfm_fp_stat_t               fp_stat_in,
	input wire logic                                  status_we_in,
	input wire logic [31:0]                           status_wdata_in,
	input wire logic                                  sticky_we_in,
	input wire logic [31:0]                           sticky_wdata_in,
	input wire asfm_pkg::asfm_mult_req_t              mult_req_in,
	input wire logic [31:0]                           arith_status_word_out,
	input wire logic [31:0]                           sticky_status_word_out,
	input wire asfm_pkg::asfm_rf_wr_t                 alu_wr_out,
	input wire asfm_pkg::asfm_rf_wr_t                 mult_wr_out,
	input wire logic [ACC_COUNT*asfm_pkg::PROD_W-1:0] mult_result_accumulator_out
);
	default clocking dc @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);
	logic alu_go;
	logic cmp_op;
	logic fp_op;
	logic sign_op;
	assign alu_go = alu_req_in.valid && !status_we_in;
	assign cmp_op = alu_req_in.op inside {asfm_pkg::ASFM_OP_COMP, asfm_pkg::ASFM_OP_FCOMP};
	assign fp_op = alu_req_in.op >= asfm_pkg::ASFM_OP_FLOAT;
	assign sign_op = alu_req_in.op inside {asfm_pkg::ASFM_OP_MAG, asfm_pkg::ASFM_OP_FMAG, asfm_pkg::ASFM_OP_FSIGX};

	property p_sw_status;
		status_we_in |=> arith_status_word_out == $past(status_wdata_in);
	endproperty
	a_sw_status: assert property (p_sw_status) else $error("status write lost");
	property p_sw_sticky;
		sticky_we_in |=> sticky_status_word_out == $past(sticky_wdata_in);
	endproperty
	a_sw_sticky: assert property (p_sw_sticky) else $error("sticky write lost");
	property p_sticky_keep;
		!sticky_we_in |=> (sticky_status_word_out & $past(sticky_status_word_out)) == $past(sticky_status_word_out);
	endproperty
	a_sticky_keep: assert property (p_sticky_keep) else $error("sticky bit dropped");
	property p_hist_keep;
		!status_we_in && !(alu_req_in.valid && cmp_op) |=> $stable(arith_status_word_out[31:24]);
	endproperty
	a_hist_keep: assert property (p_hist_keep) else $error("history moved");
	property p_hist_shift;
		alu_go && cmp_op |=> arith_status_word_out[30:24] == $past(arith_status_word_out[31:25]);
	endproperty
	a_hist_shift: assert property (p_hist_shift) else $error("history not shifted");
	property p_cmp_nowr;
		alu_req_in.valid && cmp_op |=> !alu_wr_out.we;
	endproperty
	a_cmp_nowr: assert property (p_cmp_nowr) else $error("compare wrote a result");
	property p_wr_pulse;
		alu_req_in.valid && !cmp_op |=> alu_wr_out.we;
	endproperty
	a_wr_pulse: assert property (p_wr_pulse) else $error("result write missing");
	property p_float_flag;
		alu_go |=> arith_status_word_out[asfm_pkg::ST_FLOAT_BIT] == $past(fp_op);
	endproperty
	a_float_flag: assert property (p_float_flag) else $error("float flag wrong");
	property p_sign_clr;
		alu_go && !sign_op |=> !arith_status_word_out[asfm_pkg::ST_SIGN_BIT];
	endproperty
	a_sign_clr: assert property (p_sign_clr) else $error("sign flag not cleared");
	property p_flag_hold;
		!alu_req_in.valid && !status_we_in |=> $stable(arith_status_word_out[5:0]);
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("idle flag change");
	property p_mult_wr;
		mult_req_in.valid && mult_req_in.dest inside {asfm_pkg::ASFM_MD_TO_RF, asfm_pkg::ASFM_MD_FLOAT}
			|=> mult_wr_out.we;
	endproperty
	a_mult_wr: assert property (p_mult_wr) else $error("product write missing");
endmodule // asfm_core_monitor

// [verification/asfm_rf_model.sv]
// Register file model standing at the far side of the block.
`timescale 1ns/100ps
module asfm_rf_model (
	input  wire logic                  core_clk_in,
	input  wire asfm_pkg::asfm_rf_wr_t alu_wr_in,
	input  wire asfm_pkg::asfm_rf_wr_t mult_wr_in,
	input  wire logic [3:0]            dst_in,
	input  wire logic [3:0]            rd_addr_in,
	output logic [39:0]                rd_data_out
);
	logic [39:0] regs [16];
	initial begin
		for (int i = 0; i < 16; i++) begin
			regs[i] = 40'(i) << 8;
		end
	end
	// Reads are immediate and writes land on the edge, so one entry may be source and destination at once.
	assign rd_data_out = regs[rd_addr_in];
	always @(posedge core_clk_in) begin
		if (alu_wr_in.we) begin
			regs[dst_in] <= alu_wr_in.data;
		end
		if (mult_wr_in.we) begin
			regs[dst_in] <= mult_wr_in.data;
		end
	end
endmodule // asfm_rf_model

// [verification/testbench.sv]
// Self-checking testbench of the ALU status and multiplier block.
`timescale 1ns/100ps
`define CHK(g, e) chk((g), (e))
module testbench;
	logic                    core_clk_in = 1'b0;
	logic                    rstn_in = 1'b0;
	logic                    clamp = 1'b0;
	asfm_pkg::asfm_alu_req_t alu_req = '0;
	asfm_pkg::asfm_fp_stat_t fp = '0;
	asfm_pkg::asfm_mult_req_t mreq = '0;
	logic                    st_we = 1'b0;
	logic [31:0]             st_wd = '0;
	logic                    sk_we = 1'b0;
	logic [31:0]             sk_wd = '0;
	logic [31:0]             status;
	logic [31:0]             sticky;
	asfm_pkg::asfm_rf_wr_t   alu_wr;
	asfm_pkg::asfm_rf_wr_t   mult_wr;
	logic [159:0]            acc;
	logic [3:0]              dst = 4'h3;
	logic [39:0]             rd_data;
	int                      mismatches = 0;
	int                      n_tests = 0;
	int                      cycles = 0;

	always #2.5 core_clk_in = ~core_clk_in;

	asfm_core #(.ACC_COUNT(2)) u_dut (
		.core_clk_in(core_clk_in), .rstn_in(rstn_in), .overflow_clamp_enable_in(clamp),
		.alu_req_in(alu_req), .fp_stat_in(fp), .status_we_in(st_we), .status_wdata_in(st_wd),
		.sticky_we_in(sk_we), .sticky_wdata_in(sk_wd), .mult_req_in(mreq),
		.arith_status_word_out(status), .sticky_status_word_out(sticky), .alu_wr_out(alu_wr),
		.mult_wr_out(mult_wr), .mult_result_accumulator_out(acc)
	);
	asfm_rf_model u_rf (
		.core_clk_in(core_clk_in), .alu_wr_in(alu_wr), .mult_wr_in(mult_wr), .dst_in(dst),
		.rd_addr_in(dst), .rd_data_out(rd_data)
	);

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	always @(posedge core_clk_in) begin
		cycles++;
		if (cycles == 2000) begin
			mismatches++;
			print_verdict();
		end
	end

	task automatic chk(input logic [159:0] g, input logic [159:0] e);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// Low bytes of operands are junk on purpose; fixed operations must ignore them.
	task automatic alu(input asfm_pkg::asfm_alu_op_t op, input logic [31:0] x, input logic [31:0] y);
		alu_req.valid = 1'b1;
		alu_req.op = op;
		alu_req.x = {x, 8'h5A};
		alu_req.y = {y, 8'hA5};
		@(posedge core_clk_in);
		#1;
		alu_req.valid = 1'b0;
		st_we = 1'b0;
		sk_we = 1'b0;
		fp = '0;
	endtask

	task automatic mul(input asfm_pkg::asfm_mult_dest_t d, input logic s, input logic [2:0] f,
		input logic [31:0] x, input logic [31:0] y);
		mreq.valid = 1'b1;
		mreq.dest = d;
		mreq.acc_sel = s;
		{mreq.fractional, mreq.x_signed, mreq.y_signed} = f;
		mreq.x = {x, 8'hC3};
		mreq.y = {y, 8'h3C};
		@(posedge core_clk_in);
		#1;
		mreq.valid = 1'b0;
	endtask

	initial begin
		repeat (8) @(posedge core_clk_in);
		#1;
		rstn_in = 1'b1;
		`CHK(status, 32'h0000_0000);
		alu(asfm_pkg::ASFM_OP_ADD, 32'h7FFF_FFFF, 32'h0000_0001);
		`CHK(alu_wr.data, 40'h80_0000_0000);
		`CHK(status, 32'h0000_0006);
		`CHK(sticky, 32'h0000_0004);
		alu(asfm_pkg::ASFM_OP_ADD, 32'hFFFF_FFFF, 32'h0000_0001);
		`CHK(status, 32'h0000_0009);
		`CHK(sticky, 32'h0000_0004);
		alu(asfm_pkg::ASFM_OP_ADDC, 32'h0000_0000, 32'h0000_0000);
		`CHK(alu_wr.data, 40'h00_0000_0100);
		alu(asfm_pkg::ASFM_OP_AND, 32'hFFFF_FFFF, 32'h8000_0000);
		`CHK(status, 32'h0000_0004);
		alu(asfm_pkg::ASFM_OP_MAG, 32'hFFFF_FFFF, 32'h0000_0000);
		`CHK(status, 32'h0000_0010);
		alu(asfm_pkg::ASFM_OP_SUBB, 32'h0000_0005, 32'h0000_0003);
		`CHK(alu_wr.data, 40'h00_0000_0100);
		alu(asfm_pkg::ASFM_OP_LIMIT, 32'h0000_0010, 32'h0000_0005);
		`CHK(alu_wr.data, 40'h00_0000_0500);
		`CHK(status, 32'h0000_0000);
		$display("test fixed flags done");
		alu(asfm_pkg::ASFM_OP_COMP, 32'h0000_0005, 32'h0000_0003);
		`CHK(status[31:24], 8'h80);
		`CHK(alu_wr.we, 1'b0);
		alu(asfm_pkg::ASFM_OP_COMP, 32'h0000_0003, 32'h0000_0005);
		`CHK(status[31:24], 8'h40);
		alu(asfm_pkg::ASFM_OP_ADD, 32'h0000_0001, 32'h0000_0001);
		`CHK(status[31:24], 8'h40);
		$display("test compare history done");
		fp.exponent = 10'sd128;
		fp.negative = 1'b1;
		alu(asfm_pkg::ASFM_OP_FLOAT, 32'h0000_0000, 32'h0000_0000);
		`CHK(status, 32'h4000_0406);
		`CHK(sticky, 32'h0000_0006);
		fp.exponent = 10'sd127;
		alu(asfm_pkg::ASFM_OP_FLOAT, 32'h0000_0000, 32'h0000_0000);
		`CHK(status, 32'h4000_0400);
		fp.underflow = 1'b1;
		alu(asfm_pkg::ASFM_OP_FLOAT, 32'h0000_0000, 32'h0000_0000);
		`CHK(status, 32'h4000_0401);
		`CHK(sticky, 32'h0000_0007);
		fp.conv_overflow = 1'b1;
		alu(asfm_pkg::ASFM_OP_FTOFIX, 32'h0000_0000, 32'h0000_0000);
		`CHK(status[5], 1'b1);
		`CHK(sticky, 32'h0000_0027);
		clamp = 1'b1;
		fp.conv_overflow = 1'b1;
		alu(asfm_pkg::ASFM_OP_FTOFIX, 32'h0000_0000, 32'h0000_0000);
		`CHK(status[5], 1'b0);
		alu(asfm_pkg::ASFM_OP_ADD, 32'h7FFF_FFFF, 32'h0000_0001);
		`CHK(alu_wr.data, 40'h7F_FFFF_FF00);
		`CHK(status[1], 1'b1);
		clamp = 1'b0;
		$display("test float flags done");
		st_we = 1'b1;
		st_wd = 32'h0000_0008;
		sk_we = 1'b1;
		sk_wd = 32'h0000_0000;
		alu(asfm_pkg::ASFM_OP_ADD, 32'h7FFF_FFFF, 32'h0000_0001);
		`CHK(status, 32'h0000_0008);
		`CHK(sticky, 32'h0000_0000);
		alu(asfm_pkg::ASFM_OP_ADDC, 32'h0000_0000, 32'h0000_0000);
		`CHK(alu_wr.data, 40'h00_0000_0100);
		// The register file model lands a registered result one edge later, so let it settle first.
		@(posedge core_clk_in);
		#1;
		`CHK(rd_data, 40'h00_0000_0100);
		alu(asfm_pkg::ASFM_OP_ADD, rd_data[39:8], rd_data[39:8]);
		@(posedge core_clk_in);
		#1;
		`CHK(rd_data, 40'h00_0000_0200);
		$display("test software write done");
		mul(asfm_pkg::ASFM_MD_TO_RF, 1'b0, 3'b111, 32'h4000_0000, 32'h4000_0000);
		`CHK(mult_wr.data, 40'h20_0000_0000);
		mul(asfm_pkg::ASFM_MD_TO_RF, 1'b0, 3'b101, 32'h8000_0000, 32'h4000_0000);
		`CHK(mult_wr.data, 40'h20_0000_0000);
		mul(asfm_pkg::ASFM_MD_TO_RF, 1'b0, 3'b000, 32'hFFFF_FFFF, 32'h0000_0002);
		`CHK(mult_wr.data, 40'hFF_FFFF_FE00);
		mul(asfm_pkg::ASFM_MD_ACCADD, 1'b1, 3'b011, 32'h0000_0003, 32'hFFFF_FFFE);
		`CHK(acc, {80'hFFFF_FFFF_FFFF_FFFF_FFFA, 80'h0});
		mul(asfm_pkg::ASFM_MD_ACCSUB, 1'b1, 3'b011, 32'h0000_0003, 32'hFFFF_FFFE);
		`CHK(acc, 160'h0);
		mul(asfm_pkg::ASFM_MD_LOAD, 1'b0, 3'b000, 32'h0000_0002, 32'h0000_0003);
		`CHK(acc, 160'h6);
		mreq.fp_product = 40'h12_3456_789A;
		mul(asfm_pkg::ASFM_MD_FLOAT, 1'b0, 3'b000, 32'h0000_0000, 32'h0000_0000);
		`CHK(mult_wr.data, 40'h12_3456_789A);
		$display("test multiplier done");
		print_verdict();
	end
endmodule // testbench

bind asfm_core asfm_core_monitor #(.ACC_COUNT(ACC_COUNT)) u_mon (
	.core_clk_in(core_clk_in), .rstn_in(rstn_in), .overflow_clamp_enable_in(overflow_clamp_enable_in),
	.alu_req_in(alu_req_in), .fp_stat_in(fp_stat_in), .status_we_in(status_we_in),
	.status_wdata_in(status_wdata_in), .sticky_we_in(sticky_we_in), .sticky_wdata_in(sticky_wdata_in),
	.mult_req_in(mult_req_in), .arith_status_word_out(arith_status_word_out),
	.sticky_status_word_out(sticky_status_word_out), .alu_wr_out(alu_wr_out), .mult_wr_out(mult_wr_out),
	.mult_result_accumulator_out(mult_result_accumulator_out)
);
